// ==== hw/ilc_ctrl.sv ====
/*
 * Per-line control and status logic of a 32-line parallel I/O controller,
 * reached over an APB slave port. Drives pad level, output enable, pull-up
 * and peripheral A/B choice; reads pad levels through a two-stage synchroniser.
 * Assumes one 50 MHz clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
`include "ilc_defines.svh"

module ilc_ctrl (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire ilc_pkg::ilc_apb_req_t apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire ilc_pkg::ilc_lines_t   pad_in,
  output ilc_pkg::ilc_pad_t          pad_out,
  output ilc_pkg::ilc_lines_t        change_irq_lines
);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic                   wr_en;
  logic                   rd_en;
  logic [`ILC_AW-1:0]     addr;
  logic [31:0]            wdata;
  logic                   addr_ok;

  // The slave answers in the first access cycle, so every transfer has no wait.
  assign pready  = 1'b1;
  assign addr    = apb_req.paddr;
  assign wdata   = apb_req.pwdata;
  assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en   = apb_req.psel && apb_req.penable && !apb_req.pwrite;

  // Write strobes for clocked processes only; an assign would miss the signals it reads.
  function automatic logic [31:0] wstrobe(input logic [`ILC_AW-1:0] off);
    wstrobe = (wr_en && addr == off) ? wdata : 32'h0000_0000;
  endfunction

  // --------------------------------------------------------------------------
  // Pad input synchroniser and change detection
  // --------------------------------------------------------------------------
  ilc_pkg::ilc_lines_t pin_meta_q;
  ilc_pkg::ilc_lines_t pin_sync_q;
  ilc_pkg::ilc_lines_t pin_prev_q;
  ilc_pkg::ilc_lines_t change;

  // The first stage is read only by the second; edges are taken after stage two.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_q <= 32'h0000_0000;
      pin_sync_q <= 32'h0000_0000;
      pin_prev_q <= 32'h0000_0000;
    end else begin
      pin_meta_q <= pad_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // A difference between two synchronised samples is a level change.
  assign change = pin_sync_q ^ pin_prev_q;

  // --------------------------------------------------------------------------
  // Output value and direct write permission
  // --------------------------------------------------------------------------
  ilc_pkg::ilc_lines_t out_value_q;
  ilc_pkg::ilc_lines_t out_value_d;
  ilc_pkg::ilc_lines_t dw_state_q;
  ilc_pkg::ilc_lines_t out_clr;
  ilc_pkg::ilc_lines_t value_wr;

  // Enable sets, disable clears; zero bits leave the permission alone.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dw_state_q <= `ILC_RST_DW_STATE;
    end else begin
      dw_state_q <= (dw_state_q | wstrobe(`ILC_OFF_DW_ENABLE))
                    & ~wstrobe(`ILC_OFF_DW_DISABLE);
    end
  end

  assign out_clr  = (wr_en && addr == `ILC_OFF_OUT_CLEAR) ? wdata : 32'h0000_0000;
  assign value_wr = (wr_en && addr == `ILC_OFF_OUT_VALUE) ? dw_state_q : 32'h0000_0000;

  // Direct writes reach only permitted lines; clear acts on ones it names.
  always_comb begin
    out_value_d = (out_value_q & ~value_wr) | (wdata & value_wr);
    out_value_d = out_value_d & ~out_clr;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_value_q <= `ILC_RST_OUT_VALUE;
    end else begin
      out_value_q <= out_value_d;
    end
  end

  // --------------------------------------------------------------------------
  // Change interrupt mask and pending bits
  // --------------------------------------------------------------------------
  ilc_pkg::ilc_lines_t irq_mask_q;
  ilc_pkg::ilc_lines_t pending_q;
  logic                pend_rd;
  logic [31:0]         prdata_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_q <= `ILC_RST_IRQ_MASK;
    end else begin
      irq_mask_q <= (irq_mask_q | wstrobe(`ILC_OFF_IRQ_ENABLE))
                    & ~wstrobe(`ILC_OFF_IRQ_DISABLE);
    end
  end

  assign pend_rd = rd_en && addr == `ILC_OFF_IRQ_PENDING;

  // The read clears only the bits it returned, so a change in the same cycle,
  // or one after the read data was captured, stays pending for the next read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pending_q <= 32'h0000_0000;
    end else if (pend_rd) begin
      pending_q <= (pending_q & ~prdata_q) | change;
    end else begin
      pending_q <= pending_q | change;
    end
  end

  // Per-line requests; the mask gates them, the system combines them.
  assign change_irq_lines = pending_q & irq_mask_q;

  // --------------------------------------------------------------------------
  // Open-drain, pull-up and peripheral choice
  // --------------------------------------------------------------------------
  ilc_pkg::ilc_lines_t od_state_q;
  ilc_pkg::ilc_lines_t pu_off_q;
  ilc_pkg::ilc_lines_t periph_b_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      od_state_q <= `ILC_RST_OD_STATE;
    end else begin
      od_state_q <= (od_state_q | wstrobe(`ILC_OFF_OD_ENABLE))
                    & ~wstrobe(`ILC_OFF_OD_DISABLE);
    end
  end

  // Stored in inverted sense so the state register reads directly.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pu_off_q <= `ILC_RST_PU_OFF;
    end else begin
      pu_off_q <= (pu_off_q | wstrobe(`ILC_OFF_PU_DISABLE))
                  & ~wstrobe(`ILC_OFF_PU_ENABLE);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periph_b_q <= `ILC_RST_PERIPH;
    end else begin
      periph_b_q <= (periph_b_q | wstrobe(`ILC_OFF_PERIPH_SECOND))
                    & ~wstrobe(`ILC_OFF_PERIPH_FIRST);
    end
  end

  // --------------------------------------------------------------------------
  // Pad drive
  // --------------------------------------------------------------------------
  // Open-drain lines only enable the driver while the value is low.
  always_comb begin
    pad_out.level     = out_value_q;
    pad_out.oe        = ~od_state_q | ~out_value_q;
    pad_out.pullup_on = ~pu_off_q;
    pad_out.periph_b  = periph_b_q;
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [31:0] rdata_d;
  logic        rd_hit;

  always_comb begin
    rdata_d = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (addr)
      `ILC_OFF_OUT_VALUE:     rdata_d = out_value_q;
      `ILC_OFF_PIN_READBACK:  rdata_d = pin_sync_q;
      `ILC_OFF_IRQ_MASK:      rdata_d = irq_mask_q;
      `ILC_OFF_IRQ_PENDING:   rdata_d = pending_q;
      `ILC_OFF_OD_STATE:      rdata_d = od_state_q;
      `ILC_OFF_PU_STATE:      rdata_d = pu_off_q;
      `ILC_OFF_PERIPH_STATE:  rdata_d = periph_b_q;
      `ILC_OFF_DW_STATE:      rdata_d = dw_state_q;
      `ILC_OFF_OUT_CLEAR,
      `ILC_OFF_IRQ_ENABLE,
      `ILC_OFF_IRQ_DISABLE,
      `ILC_OFF_OD_ENABLE,
      `ILC_OFF_OD_DISABLE,
      `ILC_OFF_PU_DISABLE,
      `ILC_OFF_PU_ENABLE,
      `ILC_OFF_PERIPH_FIRST,
      `ILC_OFF_PERIPH_SECOND,
      `ILC_OFF_DW_ENABLE,
      `ILC_OFF_DW_DISABLE:    rdata_d = 32'h0000_0000;
      default:                rd_hit  = 1'b0;
    endcase
  end

  // Read data is captured at the end of the setup cycle, so the access cycle
  // presents a flop; the pending clear above relies on exactly this copy.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      prdata_q <= rdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = apb_req.psel && apb_req.penable && !rd_hit;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_dw_en;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_DW_ENABLE)
      |=> (dw_state_q & $past(wdata)) == $past(wdata);
  endproperty
  a_dw_en: assert property (p_dw_en) else $error("direct write enable failed");

  property p_dw_dis;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_DW_DISABLE)
      |=> (dw_state_q & $past(wdata)) == 32'h0000_0000;
  endproperty
  a_dw_dis: assert property (p_dw_dis) else $error("direct write disable failed");

  property p_od_en;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_OD_ENABLE)
      |=> (od_state_q & $past(wdata)) == $past(wdata);
  endproperty
  a_od_en: assert property (p_od_en) else $error("open-drain enable failed");

  property p_od_dis;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_OD_DISABLE)
      |=> (od_state_q & $past(wdata)) == 32'h0000_0000;
  endproperty
  a_od_dis: assert property (p_od_dis) else $error("open-drain disable failed");

  property p_pu_dis;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_PU_DISABLE)
      |=> (pad_out.pullup_on & $past(wdata)) == 32'h0000_0000;
  endproperty
  a_pu_dis: assert property (p_pu_dis) else $error("pull-up disable failed");

  property p_pu_en;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_PU_ENABLE)
      |=> (pad_out.pullup_on & $past(wdata)) == $past(wdata);
  endproperty
  a_pu_en: assert property (p_pu_en) else $error("pull-up enable failed");

  property p_pa_sel;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_PERIPH_FIRST)
      |=> (pad_out.periph_b & $past(wdata)) == 32'h0000_0000;
  endproperty
  a_pa_sel: assert property (p_pa_sel) else $error("peripheral A select failed");

  property p_pb_sel;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_PERIPH_SECOND)
      |=> (pad_out.periph_b & $past(wdata)) == $past(wdata);
  endproperty
  a_pb_sel: assert property (p_pb_sel) else $error("peripheral B select failed");

  property p_pend_set;
    @(posedge clk) disable iff (!nrst)
      (change != 32'h0000_0000)
      |=> (pending_q & $past(change)) == $past(change);
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("change not recorded");

  property p_value_write;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_OUT_VALUE)
      |=> (out_value_q & $past(dw_state_q)) == ($past(wdata) & $past(dw_state_q));
  endproperty
  a_value_write: assert property (p_value_write) else $error("permitted write lost");

  property p_value_locked;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_OUT_VALUE)
      |=> (out_value_q & ~$past(dw_state_q)) == ($past(out_value_q) & ~$past(dw_state_q));
  endproperty
  a_value_locked: assert property (p_value_locked) else $error("locked line changed");

  property p_clear;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_OUT_CLEAR) |=> (out_value_q & $past(wdata)) == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not clear");

  property p_mask_en;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_IRQ_ENABLE) |=> (irq_mask_q & $past(wdata)) == $past(wdata);
  endproperty
  a_mask_en: assert property (p_mask_en) else $error("irq enable failed");

  property p_mask_dis;
    @(posedge clk) disable iff (!nrst)
      (wr_en && addr == `ILC_OFF_IRQ_DISABLE) |=> (irq_mask_q & $past(wdata)) == 32'h0000_0000;
  endproperty
  a_mask_dis: assert property (p_mask_dis) else $error("irq disable failed");

  property p_pend_keep;
    @(posedge clk) disable iff (!nrst)
      (pend_rd && change != 32'h0000_0000) |=> (pending_q & $past(change)) == $past(change);
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("change lost at read");

  property p_pend_clr;
    @(posedge clk) disable iff (!nrst)
      (pend_rd && change == 32'h0000_0000)
      |=> (pending_q & $past(prdata)) == 32'h0000_0000;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("read did not clear");

  property p_od_high;
    @(posedge clk) disable iff (!nrst)
      ((od_state_q & pad_out.oe & pad_out.level) == 32'h0000_0000);
  endproperty
  a_od_high: assert property (p_od_high) else $error("open-drain line driven high");

  property p_pp_drive;
    @(posedge clk) disable iff (!nrst)
      ((~od_state_q & ~pad_out.oe) == 32'h0000_0000);
  endproperty
  a_pp_drive: assert property (p_pp_drive) else $error("push-pull line not driven");

  property p_readback;
    @(posedge clk) disable iff (!nrst)
      (rd_en && addr == `ILC_OFF_PIN_READBACK) |-> prdata == $past(pin_sync_q);
  endproperty
  a_readback: assert property (p_readback) else $error("pin readback wrong");

endmodule

// ==== hw/ilc_defines.svh ====
/*
 * Register offsets, reset values and widths for the I/O line controller.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef ILC_DEFINES_SVH
`define ILC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ILC_OFF_OUT_CLEAR     12'h034
`define ILC_OFF_OUT_VALUE     12'h038
`define ILC_OFF_PIN_READBACK  12'h03c
`define ILC_OFF_IRQ_ENABLE    12'h040
`define ILC_OFF_IRQ_DISABLE   12'h044
`define ILC_OFF_IRQ_MASK      12'h048
`define ILC_OFF_IRQ_PENDING   12'h04c
`define ILC_OFF_OD_ENABLE     12'h050
`define ILC_OFF_OD_DISABLE    12'h054
`define ILC_OFF_OD_STATE      12'h058
`define ILC_OFF_PU_DISABLE    12'h060
`define ILC_OFF_PU_ENABLE     12'h064
`define ILC_OFF_PU_STATE      12'h068
`define ILC_OFF_PERIPH_FIRST  12'h070
`define ILC_OFF_PERIPH_SECOND 12'h074
`define ILC_OFF_PERIPH_STATE  12'h078
`define ILC_OFF_DW_ENABLE     12'h0a0
`define ILC_OFF_DW_DISABLE    12'h0a4
`define ILC_OFF_DW_STATE      12'h0a8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ILC_RST_OUT_VALUE     32'h0000_0000
`define ILC_RST_IRQ_MASK      32'h0000_0000
`define ILC_RST_OD_STATE      32'h0000_0000
`define ILC_RST_PU_OFF        32'h0000_0000
`define ILC_RST_PERIPH        32'h0000_0000
`define ILC_RST_DW_STATE      32'h0000_0000

`define ILC_LINES             32
`define ILC_AW                12

`endif

// ==== hw/ilc_pkg.sv ====
/*
 * Types shared by the I/O line controller.
 * Assumes ilc_defines.svh is on the include path.
 */
`include "ilc_defines.svh"

package ilc_pkg;

  typedef logic [`ILC_LINES-1:0] ilc_lines_t;

  // Pin drive towards the pads, one bit per line.
  typedef struct packed {
    ilc_lines_t level;
    ilc_lines_t oe;
    ilc_lines_t pullup_on;
    ilc_lines_t periph_b;
  } ilc_pad_t;

  // APB request as seen by the slave.
  typedef struct packed {
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [`ILC_AW-1:0] paddr;
    logic [31:0]        pwdata;
  } ilc_apb_req_t;

endpackage

// ==== verif/ilc_pad_model.sv ====
/*
 * Pin model for the I/O line controller: resolves each pad from the
 * controller drive, an external driver and the pull-up.
 * Assumes the bench keeps the external driver off push-pull lines.
 */
`timescale 1ns/100ps

module ilc_pad_model (
  input  wire logic                clk,
  input  wire ilc_pkg::ilc_pad_t   pad_out,
  input  wire ilc_pkg::ilc_lines_t ext_en,
  input  wire ilc_pkg::ilc_lines_t ext_val,
  output ilc_pkg::ilc_lines_t      pin
);
  ilc_pkg::ilc_lines_t float_q = '0;
  ilc_pkg::ilc_lines_t drv_lo;
  ilc_pkg::ilc_lines_t drv_hi;

  // ---------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------
  // A floating line toggles every cycle so that a stale value never reads as valid.
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Low wins on contention, as on a wired-and bus.
  always_comb begin
    drv_lo = (pad_out.oe & ~pad_out.level) | (ext_en & ~ext_val);
    drv_hi = (pad_out.oe & pad_out.level) | (ext_en & ext_val);
    pin    = ~drv_lo & (drv_hi | pad_out.pullup_on | float_q);
  end
endmodule

// ==== verif/tb_ilc_ctrl.sv ====
/*
 * Self-checking bench for the I/O line controller over APB.
 * Assumes the pin model sits on the pad side and a 50 MHz clock.
 */
`timescale 1ns/100ps
`include "ilc_defines.svh"

module tb_ilc_ctrl;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  ilc_pkg::ilc_apb_req_t req = '0;
  logic                  pready;
  logic [31:0]           prdata;
  logic                  pslverr;
  ilc_pkg::ilc_lines_t   pad_in;
  ilc_pkg::ilc_lines_t   irq;
  ilc_pkg::ilc_lines_t   ext_en = '0;
  ilc_pkg::ilc_lines_t   ext_val = '0;
  ilc_pkg::ilc_pad_t     pad_out;
  int                    bad_count = 0;
  int                    total_checks = 0;
  logic [11:0] set_a [5] = '{`ILC_OFF_IRQ_ENABLE, `ILC_OFF_OD_ENABLE,
    `ILC_OFF_PU_DISABLE, `ILC_OFF_PERIPH_SECOND, `ILC_OFF_DW_ENABLE};
  logic [11:0] clr_a [5] = '{`ILC_OFF_IRQ_DISABLE, `ILC_OFF_OD_DISABLE,
    `ILC_OFF_PU_ENABLE, `ILC_OFF_PERIPH_FIRST, `ILC_OFF_DW_DISABLE};
  logic [11:0] st_a [5] = '{`ILC_OFF_IRQ_MASK, `ILC_OFF_OD_STATE,
    `ILC_OFF_PU_STATE, `ILC_OFF_PERIPH_STATE, `ILC_OFF_DW_STATE};
  logic [31:0] sh [5] = '{default: 32'h0000_0000};
  logic [31:0] lvl = 32'h0000_0000;
  logic [31:0] q, q2, r1, r2, x, e;
  logic        err;

  always #10 clk = ~clk;

  ilc_ctrl u_ilc_ctrl (.clk(clk), .nrst(nrst), .apb_req(req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .change_irq_lines(irq));

  ilc_pad_model u_ilc_pad_model (.clk(clk), .pad_out(pad_out), .ext_en(ext_en),
    .ext_val(ext_val), .pin(pad_in));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x_e, input string m);
    total_checks++;
    if (g !== x_e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, x_e);
    end
  endtask

  // One APB transfer, entered just after a rising edge; an idle cycle follows.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    if (n >= 50) begin
      bad_count++;
      end_of_test();
    end
    req <= '0;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    x = $urandom(32'h53d2eed0);
    idle(6);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, st_a[i], '0);
      chk(q, 32'h0000_0000, "state reset");
    end
    chk(pad_out.oe, 32'hffff_ffff, "oe reset");
    chk(pad_out.pullup_on, 32'hffff_ffff, "pullup reset");
    apb(1'b0, 12'h0fc, '0);
    chk({31'h0, err}, 32'h0000_0001, "unmapped slverr");
    apb(1'b1, `ILC_OFF_IRQ_MASK, 32'hffff_ffff);
    apb(1'b0, `ILC_OFF_IRQ_MASK, '0);
    chk(q, 32'h0000_0000, "mask read-only");
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 5; i++) begin
        r1 = $urandom;
        r2 = $urandom;
        apb(1'b1, set_a[i], r1);
        apb(1'b1, clr_a[i], r2);
        sh[i] = (sh[i] | r1) & ~r2;
        apb(1'b0, st_a[i], '0);
        chk(q, sh[i], "set clear state");
      end
      chk(pad_out.pullup_on, ~sh[2], "pullup pins");
      chk(pad_out.periph_b, sh[3], "periph pins");
      r1 = $urandom;
      apb(1'b1, `ILC_OFF_OUT_VALUE, r1);
      lvl = (lvl & ~sh[4]) | (r1 & sh[4]);
      apb(1'b0, `ILC_OFF_OUT_VALUE, '0);
      chk(q, lvl, "value write");
      r2 = $urandom;
      apb(1'b1, `ILC_OFF_OUT_CLEAR, r2);
      lvl = lvl & ~r2;
      chk(pad_out.level, lvl, "level after clear");
      chk(pad_out.oe, ~sh[1] | ~lvl, "drive enable");
      e = sh[1] & lvl;
      x = $urandom;
      ext_en <= e;
      ext_val <= x;
      idle(3);
      apb(1'b0, `ILC_OFF_PIN_READBACK, '0);
      chk(q, (lvl & ~e) | (x & e), "pin readback");
    end
    $display("set clear test done");
    apb(1'b1, `ILC_OFF_OD_ENABLE, 32'hffff_ffff);
    apb(1'b1, `ILC_OFF_DW_ENABLE, 32'hffff_ffff);
    apb(1'b1, `ILC_OFF_OUT_VALUE, 32'hffff_ffff);
    ext_en <= 32'hffff_ffff;
    idle(5);
    apb(1'b0, `ILC_OFF_IRQ_PENDING, '0);
    x = $urandom;
    ext_val <= ext_val ^ x;
    idle(5);
    chk(irq, x & sh[0], "irq lines");
    apb(1'b0, `ILC_OFF_IRQ_PENDING, '0);
    chk(q, x, "pending set");
    apb(1'b0, `ILC_OFF_IRQ_PENDING, '0);
    chk(q, 32'h0000_0000, "pending cleared");
    // The change lands on the read's own edge; it must survive to one of the two reads.
    x = $urandom;
    ext_val <= ext_val ^ x;
    @(posedge clk);
    apb(1'b0, `ILC_OFF_IRQ_PENDING, '0);
    q2 = q;
    idle(4);
    apb(1'b0, `ILC_OFF_IRQ_PENDING, '0);
    chk(q | q2, x, "change kept");
    chk(q & q2, 32'h0000_0000, "change once");
    $display("change test done");
    end_of_test();
  end
endmodule
